// File: verilog/ive_map.svh
`ifndef IVE_MAP_SVH
`define IVE_MAP_SVH
// number of request sources and level width
`define IVE_NSRC 4
`define IVE_LVLW 2
// vector addresses
`define IVE_VEC_RESET 16'hfffe
`define IVE_VEC_TOP 16'hfffa
// reset values
`define IVE_MASK_RST 1'b0
`define IVE_PEND_RST 1'b0
// length of the unwanted reset pulse, in cycles
`define IVE_RST_CYC 4'h1
`endif

// File: verilog/ive_pkg.sv
package ive_pkg;
    typedef enum logic [1:0] {
        IVE_IDLE = 2'b00,
        IVE_VEC = 2'b01,
        IVE_RST = 2'b10
    } ive_state_t;
    typedef logic [1:0] ive_level_t;
endpackage

// File: verilog/ive_slot.sv
`timescale 1ns/10ps
`include "ive_map.svh"
module ive_slot (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // request and software strobes
    input wire logic req,
    input wire logic flag_clr,
    input wire logic mask_wr,
    input wire logic mask_wd,
    // state
    output logic pend_q,
    output logic mask_q,
    output logic clash
);
    // pending flag, a new request wins over a clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= `IVE_PEND_RST;
        end else if (ce) begin
            if (req) begin
                pend_q <= 1'b1;
            end else if (flag_clr) begin
                pend_q <= 1'b0;
            end
        end
    end

    // per-source enable bit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= `IVE_MASK_RST;
        end else if (ce && mask_wr) begin
            mask_q <= mask_wd;
        end
    end

    // request meets a flag clear in the same cycle; a mask write never counts
    assign clash = req && flag_clr;
endmodule // ive_slot

// File: verilog/ive_ctrl.sv
`timescale 1ns/10ps
`include "ive_map.svh"
// Contract
// - a request taken while the condition-code restore instruction executes yields the reset vector.
// - an active request in the same cycle as a clear of its pending flag may give an unwanted reset.
// - clearing a mask bit, not the pending flag, never gives the unwanted reset.
// - in non-nested operation a flag clear inside any handler gives no unwanted reset.
// - in nested operation a flag clear inside a handler of equal or higher level gives no unwanted reset.
// - a flag clear while that source is disabled gives no unwanted reset.
module ive_ctrl (
    // clock, reset, enable
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic CLK_EN,
    // request sources and software strobes
    input wire logic [`IVE_NSRC-1:0] IRQ_REQ,
    input wire logic [`IVE_NSRC-1:0] FLAG_CLR,
    input wire logic [`IVE_NSRC-1:0] MASK_WR,
    input wire logic [`IVE_NSRC-1:0] MASK_WDATA,
    input wire logic [2*`IVE_NSRC-1:0] SRC_LEVEL,
    // cpu context
    input wire logic CC_RESTORE_EXEC,
    input wire logic GLOBAL_DIS,
    input wire logic NESTED_MODE,
    input wire logic HANDLER_ACTIVE,
    input wire logic [1:0] HANDLER_LEVEL,
    input wire logic VEC_ACK,
    // vector and reset outputs
    output logic VEC_REQ,
    output logic [15:0] VEC_ADDR,
    output logic UNWANTED_RST,
    output logic [`IVE_NSRC-1:0] PEND_STAT
);
    logic [`IVE_NSRC-1:0] pend;
    logic [`IVE_NSRC-1:0] mask;
    logic [`IVE_NSRC-1:0] clash;
    logic [`IVE_NSRC-1:0] safe;
    logic [`IVE_NSRC-1:0] valid;
    logic win_v;
    logic [1:0] win_idx;
    ive_pkg::ive_level_t win_lvl;
    logic hazard;
    ive_pkg::ive_state_t state_q;
    ive_pkg::ive_state_t state_d;

    // one slot per source
    genvar gi;
    generate
        for (gi = 0; gi < `IVE_NSRC; gi = gi + 1) begin : g_slot
            ive_slot u_slot (
                .clk(CORE_CLK),
                .rst_n(RST_N),
                .ce(CLK_EN),
                .req(IRQ_REQ[gi]),
                .flag_clr(FLAG_CLR[gi]),
                .mask_wr(MASK_WR[gi]),
                .mask_wd(MASK_WDATA[gi]),
                .pend_q(pend[gi]),
                .mask_q(mask[gi]),
                .clash(clash[gi])
            );
        end
    endgenerate

    // safe contexts per source
    always_comb begin
        for (int i = 0; i < `IVE_NSRC; i++) begin
            safe[i] = !mask[i] || GLOBAL_DIS;
            if (HANDLER_ACTIVE && !NESTED_MODE) begin
                safe[i] = 1'b1;
            end
            if (HANDLER_ACTIVE && NESTED_MODE && HANDLER_LEVEL >= SRC_LEVEL[2*i +: 2]) begin
                safe[i] = 1'b1;
            end
        end
    end

    // a clash outside every safe context
    assign hazard = |(clash & ~safe);

    // highest level wins, lower index breaks ties
    always_comb begin
        valid = pend & mask & {`IVE_NSRC{!GLOBAL_DIS}};
        win_v = 1'b0;
        win_idx = 2'h0;
        win_lvl = 2'h0;
        for (int i = 0; i < `IVE_NSRC; i++) begin
            if (valid[i] && (!win_v || SRC_LEVEL[2*i +: 2] > win_lvl)) begin
                win_v = 1'b1;
                win_idx = i[1:0];
                win_lvl = SRC_LEVEL[2*i +: 2];
            end
        end
    end

    // sequencer: idle, vector offered, reset pulse
    always_comb begin
        state_d = state_q;
        case (state_q)
            ive_pkg::IVE_IDLE: begin
                if (hazard) begin
                    state_d = ive_pkg::IVE_RST;
                end else if (win_v) begin
                    state_d = ive_pkg::IVE_VEC;
                end
            end
            ive_pkg::IVE_VEC: begin
                if (hazard) begin
                    state_d = ive_pkg::IVE_RST;
                end else if (VEC_ACK) begin
                    state_d = ive_pkg::IVE_IDLE;
                end
            end
            ive_pkg::IVE_RST: begin
                state_d = ive_pkg::IVE_IDLE;
            end
            default: begin
                state_d = ive_pkg::IVE_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= ive_pkg::IVE_IDLE;
        end else if (CLK_EN) begin
            state_q <= state_d;
        end
    end

    // vector offer, latched when a request is taken
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            VEC_REQ <= 1'b0;
            VEC_ADDR <= `IVE_VEC_RESET;
        end else if (CLK_EN) begin
            VEC_REQ <= (state_d == ive_pkg::IVE_VEC);
            if (state_q == ive_pkg::IVE_IDLE && state_d == ive_pkg::IVE_VEC) begin
                if (CC_RESTORE_EXEC) begin
                    VEC_ADDR <= `IVE_VEC_RESET;
                end else begin
                    VEC_ADDR <= `IVE_VEC_TOP - {13'h0, win_idx, 1'b0};
                end
            end
        end
    end

    // unwanted reset pulse and pending status
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            UNWANTED_RST <= 1'b0;
            PEND_STAT <= '0;
        end else if (CLK_EN) begin
            UNWANTED_RST <= (state_d == ive_pkg::IVE_RST);
            PEND_STAT <= pend;
        end
    end

    // checks
    property p_restore_vec;
        @(posedge CORE_CLK) disable iff (!RST_N)
        (CLK_EN && state_q == ive_pkg::IVE_IDLE && !hazard && win_v && CC_RESTORE_EXEC)
            |=> (VEC_REQ && VEC_ADDR == 16'hfffe);
    endproperty
    a_restore_vec: assert property (p_restore_vec) else $error("restore without reset vector");

    property p_clash_rst;
        @(posedge CORE_CLK) disable iff (!RST_N)
        (CLK_EN && hazard && state_q != ive_pkg::IVE_RST) |=> UNWANTED_RST ##1 (!UNWANTED_RST || !$past(CLK_EN));
    endproperty
    a_clash_rst: assert property (p_clash_rst) else $error("unsafe clash gave no single reset pulse");

    property p_mask_clr;
        @(posedge CORE_CLK) disable iff (!RST_N)
        (CLK_EN && |MASK_WR && FLAG_CLR == '0) |=> !UNWANTED_RST;
    endproperty
    a_mask_clr: assert property (p_mask_clr) else $error("mask clear gave reset");

    property p_flat_handler;
        @(posedge CORE_CLK) disable iff (!RST_N)
        (CLK_EN && HANDLER_ACTIVE && !NESTED_MODE) |=> !UNWANTED_RST;
    endproperty
    a_flat_handler: assert property (p_flat_handler) else $error("reset inside flat handler");

    property p_nested_handler;
        @(posedge CORE_CLK) disable iff (!RST_N)
        (CLK_EN && HANDLER_ACTIVE && NESTED_MODE && HANDLER_LEVEL == 2'h3) |=> !UNWANTED_RST;
    endproperty
    a_nested_handler: assert property (p_nested_handler) else $error("reset inside top-level handler");

    property p_disabled;
        @(posedge CORE_CLK) disable iff (!RST_N)
        (CLK_EN && (clash & mask) == '0) |=> !UNWANTED_RST;
    endproperty
    a_disabled: assert property (p_disabled) else $error("reset from disabled source");

    property p_vec_hold;
        @(posedge CORE_CLK) disable iff (!RST_N)
        (VEC_REQ && !VEC_ACK && !hazard) |=> (VEC_REQ && $stable(VEC_ADDR)) or !$past(CLK_EN);
    endproperty
    a_vec_hold: assert property (p_vec_hold) else $error("vector dropped before ack");

    c_restore: cover property (@(posedge CORE_CLK) disable iff (!RST_N) VEC_REQ && VEC_ADDR == 16'hfffe);
    c_rst: cover property (@(posedge CORE_CLK) disable iff (!RST_N) UNWANTED_RST);
    c_vec: cover property (@(posedge CORE_CLK) disable iff (!RST_N) VEC_REQ ##1 VEC_ACK);
endmodule // ive_ctrl

// File: testbench/ive_cpu_model.sv
`timescale 1ns/10ps
module ive_cpu_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // vector handshake
    input wire logic vec_req,
    input wire logic [15:0] vec_addr,
    output logic vec_ack,
    // pace and what was taken
    input wire logic [1:0] dly,
    output logic got,
    output logic [15:0] got_addr
);
    logic [1:0] cnt_q;
    // wait dly cycles, ack, take the address on the ack edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vec_ack <= 1'b0;
            cnt_q <= 2'h0;
            got <= 1'b0;
            got_addr <= 16'h0000;
        end else begin
            got <= vec_ack;
            if (vec_ack) begin
                got_addr <= vec_addr;
                vec_ack <= 1'b0;
                cnt_q <= 2'h0;
            end else if (vec_req && cnt_q == dly) begin
                vec_ack <= 1'b1;
            end else if (vec_req) begin
                cnt_q <= cnt_q + 2'h1;
            end
        end
    end
endmodule // ive_cpu_model

// File: testbench/tb_interrupt_vector_errata_logic.sv
`timescale 1ns/10ps
module tb_interrupt_vector_errata_logic;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] irq = 4'h0, clr = 4'h0, mwr = 4'h0, mwd = 4'h0;
    logic ccr = 1'b0, gdis = 1'b1, nest = 1'b0, hact = 1'b0;
    logic [1:0] hlvl = 2'h0, dly = 2'h0;
    logic vreq, vack, urst, got;
    logic [15:0] vaddr, gaddr;
    logic [3:0] pend;
    int fail_count = 0;
    int n_compared = 0;
    // clock
    always #10 clk = ~clk;
    // source i has level i
    ive_ctrl dut (.CORE_CLK(clk), .RST_N(rst_n), .CLK_EN(1'b1), .IRQ_REQ(irq), .FLAG_CLR(clr),
        .MASK_WR(mwr), .MASK_WDATA(mwd), .SRC_LEVEL(8'he4), .CC_RESTORE_EXEC(ccr), .GLOBAL_DIS(gdis),
        .NESTED_MODE(nest), .HANDLER_ACTIVE(hact), .HANDLER_LEVEL(hlvl), .VEC_ACK(vack),
        .VEC_REQ(vreq), .VEC_ADDR(vaddr), .UNWANTED_RST(urst), .PEND_STAT(pend));
    ive_cpu_model cpu (.clk(clk), .rst_n(rst_n), .vec_req(vreq), .vec_addr(vaddr), .vec_ack(vack),
        .dly(dly), .got(got), .got_addr(gaddr));
    // compare and count
    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        n_compared++;
        if (seen !== want) begin
            fail_count++;
            $display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic give_verdict();
        $display("compared=%0d mismatches=%0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // write one enable bit
    task automatic prep(input int s, input logic en);
        mwr[s] = 1'b1;
        mwd[s] = en;
        @(negedge clk);
        mwr[s] = 1'b0;
    endtask
    // drop a pending flag behind a global disable
    task automatic clean(input int s);
        gdis = 1'b1;
        clr[s] = 1'b1;
        @(negedge clk);
        clr[s] = 1'b0;
        repeat (6) @(negedge clk);
        chk({12'h0, pend}, 16'h0);
    endtask
    // one request, the cpu takes the vector
    task automatic vec(input int s, input logic cc, input logic [1:0] d, input logic [15:0] want);
        int k;
        k = 0;
        prep(s, 1'b1);
        dly = d;
        gdis = 1'b0;
        ccr = cc;
        irq[s] = 1'b1;
        @(negedge clk);
        irq[s] = 1'b0;
        while (got !== 1'b1 && k < 20) begin
            @(negedge clk);
            k++;
        end
        chk({15'h0, got}, 16'h1);
        chk(gaddr, want);
        ccr = 1'b0;
        clean(s);
    endtask
    // restore executes behind a global disable: no vector may start
    task automatic rstr(input int s);
        prep(s, 1'b1);
        gdis = 1'b1;
        ccr = 1'b1;
        irq[s] = 1'b1;
        @(negedge clk);
        irq[s] = 1'b0;
        repeat (2) @(negedge clk);
        chk({15'h0, vreq}, 16'h0);
        ccr = 1'b0;
        clean(s);
    endtask
    // request and clear or mask write of one source in one cycle; count reset pulses
    task automatic hz(input int s, input logic c, input logic en, input logic mw, input logic ha,
        input logic ns, input logic [1:0] hl, input logic gd, input logic [15:0] want);
        logic [15:0] n;
        n = 16'h0;
        prep(s, en);
        gdis = gd;
        hact = ha;
        nest = ns;
        hlvl = hl;
        irq[s] = 1'b1;
        clr[s] = c;
        mwr[s] = mw;
        mwd[s] = 1'b0;
        @(negedge clk);
        irq[s] = 1'b0;
        clr[s] = 1'b0;
        mwr[s] = 1'b0;
        // the pulse already stands one edge after the clash
        n = {15'h0, urst};
        repeat (3) begin
            @(negedge clk);
            n = n + {15'h0, urst};
        end
        hact = 1'b0;
        chk(n, want);
        clean(s);
    endtask
    // main sequence
    initial begin
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk({14'h0, vreq, urst}, 16'h0);
        chk(vaddr, 16'hfffe);
        vec(1, 1'b0, 2'h0, 16'hfff8);
        vec(3, 1'b0, 2'h3, 16'hfff4);
        vec(2, 1'b1, 2'h0, 16'hfffe);
        rstr(1);
        hz(0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 16'h1);
        hz(1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 2'h0, 1'b0, 16'h0);
        hz(1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 2'h0, 1'b0, 16'h0);
        hz(2, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 2'h2, 1'b0, 16'h0);
        hz(1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 2'h3, 1'b0, 16'h0);
        hz(3, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 2'h2, 1'b0, 16'h1);
        hz(2, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 16'h0);
        hz(3, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 1'b1, 16'h0);
        hz(2, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 2'h0, 1'b1, 16'h0);
        give_verdict();
    end
    // watchdog
    initial begin
        #100000;
        fail_count++;
        give_verdict();
    end
endmodule // tb_interrupt_vector_errata_logic
